/* logic/cbt_timer_pair.sv */
// How it works
// - Each wide timer has four 8-bit blocks A..D, each with count and reload.
// - Blocks run alone or chain into 16-, 24- or 32-bit timers.
// - Each block counts previous overflow, the module clock, or a shared count input.
// - Each A block takes its own or the other timer's D overflow, selected per timer.
// - Each shared count input comes from an external line or a companion overflow.
// - Count and reload each sit at two addresses; the first shows all four bytes.
// - Full window byte lanes 0..3 map A..D; halves B:A and D:C; word is all.
// - Three-byte window shows C..A only; its top byte reads zero.
// - Word store to the three-byte window leaves block D; bytes and halves also work.
// - Straddling halves and a D:C:B group need no support.
// - Reload trigger is own overflow or the reload event of the next higher block.
// - Block overflows route to two service, two output and two trigger lines per timer.
// - D overflow into an A block is delayed one clock, except first D into second A.
// - First A reload into second D reload arrives one clock late.
// - First-timer-low chains get no extra delay on overflow or reload.
// - Each block's 8-bit reload register loads that block's count on the block's reload event.
// - Counting is synchronous; each block advances at most once per clock.
//
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "cbt_params.svh"

module cbt_timer_pair (
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  rst,
  // Register port
  input  wire cbt_pkg::cbt_bus_req_s bus_req,
  output logic [31:0]                rd_data,
  // Count sources
  input  wire logic [1:0]            ext_count,
  input  wire logic                  companion_low_overflow,
  input  wire logic                  companion_high_overflow,
  // Overflow routing
  output cbt_pkg::cbt_route_s        first_route,
  output cbt_pkg::cbt_route_s        second_route
);
  import cbt_pkg::*;

  // Block index: 0..3 first timer A..D, 4..7 second timer A..D
  logic [7:0]  count_reg  [8];
  logic [7:0]  reload_reg [8];
  logic [15:0] block_src;
  logic        first_timer_wrap_select;   // 1 = take the other timer's D
  logic        second_timer_wrap_select;
  logic [1:0]  count_in_src [2];
  logic [3:0]  first_timer_reload_select; // 1 = follow next higher block
  logic [3:0]  second_timer_reload_select;
  logic [23:0] route_sel;

  logic        shared_count_input_zero;
  logic        shared_count_input_one;
  logic [7:0]  inc;
  logic [7:0]  ovf;
  logic [7:0]  reload_evt;
  logic [7:0]  reload_sel_all;
  logic        first_d_ovf_q;
  logic        second_d_ovf_q;
  logic        first_a_reload_q;

  // Bus decode
  logic [2:0]  win;
  logic        three_byte;
  assign win        = bus_req.addr[5:3];
  assign three_byte = bus_req.addr[`CBT_THREE_BYTE_BIT];
  assign reload_sel_all = {second_timer_reload_select, first_timer_reload_select};

  // Lane k of a count/reload window is writable unless it is D in the three-byte view
  function automatic logic lane_writes(input logic [3:0] be, input logic three,
                                       input int k);
    lane_writes = be[k] && !(three && (k == 3));
  endfunction : lane_writes

  // Next block up from block j; a D block maps to the other timer's A when that A takes its overflow, else to its own A
  function automatic int upper_of(input int j, input logic fw, input logic sw);
    if ((j % 4) != 3) begin
      upper_of = j + 1;
    end else if (j == 3) begin
      upper_of = sw ? 4 : 0;
    end else begin
      upper_of = fw ? 0 : 4;
    end
  endfunction : upper_of

  // Walk up the reload chain until a block that reloads on its own overflow.
  // The walk is bounded, so an all-follow ring yields no reload instead of a loop.
  function automatic logic reload_walk(input int i, input logic [7:0] of,
                                       input logic [7:0] rs, input logic fw,
                                       input logic sw, input logic a_q);
    int   j;
    logic done;
    logic hit;
    j    = i;
    done = 1'b0;
    hit  = 1'b0;
    for (int k = 0; k < 8; k++) begin
      if (!done) begin
        if (!rs[j]) begin
          hit  = of[j];
          done = 1'b1;
        end else if ((j == 7) && fw) begin
          hit  = a_q;
          done = 1'b1;
        end else begin
          j = upper_of(j, fw, sw);
        end
      end
    end
    reload_walk = hit;
  endfunction : reload_walk

  // Shared count inputs
  always_comb begin
    case (cbt_csrc_e'(count_in_src[0]))
      CBT_CSRC_EXT:  shared_count_input_zero = ext_count[0];
      CBT_CSRC_LOW:  shared_count_input_zero = companion_low_overflow;
      CBT_CSRC_HIGH: shared_count_input_zero = companion_high_overflow;
      default:       shared_count_input_zero = 1'b0;
    endcase
    case (cbt_csrc_e'(count_in_src[1]))
      CBT_CSRC_EXT:  shared_count_input_one = ext_count[1];
      CBT_CSRC_LOW:  shared_count_input_one = companion_low_overflow;
      CBT_CSRC_HIGH: shared_count_input_one = companion_high_overflow;
      default:       shared_count_input_one = 1'b0;
    endcase
  end

  // Count enables and overflows, rippling A to D in index order.
  // A blocks fed through a delay flop cut the ring, so the ripple is acyclic.
  always_comb begin
    logic prev;
    prev = 1'b0;
    inc  = 8'h00;
    ovf  = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (i == 0) begin
        prev = first_timer_wrap_select ? second_d_ovf_q : first_d_ovf_q;
      end else if (i == 4) begin
        prev = second_timer_wrap_select ? ovf[3] : second_d_ovf_q;
      end else begin
        prev = ovf[i-1];
      end
      case (cbt_src_e'(block_src[2*i +: 2]))
        CBT_SRC_PREV:  inc[i] = prev;
        CBT_SRC_CLOCK: inc[i] = 1'b1;
        CBT_SRC_SHARED_COUNT_INPUT_ZERO:  inc[i] = shared_count_input_zero;
        CBT_SRC_SHARED_COUNT_INPUT_ONE:  inc[i] = shared_count_input_one;
        default:       inc[i] = 1'b0;
      endcase
      ovf[i] = inc[i] && (count_reg[i] == 8'hff);
    end
  end

  // Reload events per block
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      reload_evt[i] = reload_walk(i, ovf, reload_sel_all, first_timer_wrap_select,
                                  second_timer_wrap_select, first_a_reload_q);
    end
  end

  // Delay flops on the crossing paths
  always_ff @(posedge clock) begin
    if (rst) begin
      first_d_ovf_q    <= 1'b0;
      second_d_ovf_q   <= 1'b0;
      first_a_reload_q <= 1'b0;
    end else begin
      first_d_ovf_q    <= ovf[3];
      second_d_ovf_q   <= ovf[7];
      first_a_reload_q <= reload_evt[0];
    end
  end

  // Counters: a software write wins, then reload, then increment
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < 8; i++) begin
        count_reg[i] <= `CBT_BYTE_RST;
      end
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (bus_req.wr && (win == ((i < 4) ? 3'd0 : 3'd2))
            && lane_writes(bus_req.be, three_byte, i % 4)) begin
          count_reg[i] <= bus_req.wdata[8*(i%4) +: 8];
        end else if (reload_evt[i]) begin
          count_reg[i] <= reload_reg[i];
        end else if (inc[i]) begin
          count_reg[i] <= count_reg[i] + 8'h01;
        end
      end
    end
  end

  // Reload registers, software only
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < 8; i++) begin
        reload_reg[i] <= `CBT_BYTE_RST;
      end
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (bus_req.wr && (win == ((i < 4) ? 3'd1 : 3'd3))
            && lane_writes(bus_req.be, three_byte, i % 4)) begin
          reload_reg[i] <= bus_req.wdata[8*(i%4) +: 8];
        end
      end
    end
  end

  // Control registers
  always_ff @(posedge clock) begin
    if (rst) begin
      block_src                  <= 16'(`CBT_INPUT_CTRL_RST);
      first_timer_wrap_select    <= 1'b0;
      second_timer_wrap_select   <= 1'b0;
      count_in_src[0]            <= 2'h0;
      count_in_src[1]            <= 2'h0;
      first_timer_reload_select  <= 4'(`CBT_RELOAD_SEL_RST);
      second_timer_reload_select <= 4'(`CBT_RELOAD_SEL_RST >> 4);
      route_sel                  <= `CBT_ROUTE_SEL_RST;
    end else if (bus_req.wr) begin
      if (bus_req.addr == `CBT_OFF_INPUT_CTRL) begin
        block_src                <= bus_req.wdata[`CBT_SRC_LSB +: 16];
        first_timer_wrap_select  <= bus_req.wdata[`CBT_WRAP_FIRST_BIT];
        second_timer_wrap_select <= bus_req.wdata[`CBT_WRAP_SECOND_BIT];
        count_in_src[0]          <= bus_req.wdata[`CBT_CSRC_ZERO_LSB +: 2];
        count_in_src[1]          <= bus_req.wdata[`CBT_CSRC_ONE_LSB +: 2];
      end
      if (bus_req.addr == `CBT_OFF_RELOAD_SEL) begin
        first_timer_reload_select  <= bus_req.wdata[3:0];
        second_timer_reload_select <= bus_req.wdata[7:4];
      end
      if (bus_req.addr == `CBT_OFF_ROUTE_SEL) begin
        route_sel <= bus_req.wdata[23:0];
      end
    end
  end

  // Read data, valid the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clock) begin
    if (rst) begin
      rd_data <= 32'h0000_0000;
    end else if (bus_req.rd) begin
      rd_data <= 32'h0000_0000;
      case (bus_req.addr)
        `CBT_OFF_INPUT_CTRL: begin
          rd_data <= {10'h000, count_in_src[1], count_in_src[0],
                      second_timer_wrap_select, first_timer_wrap_select, block_src};
        end
        `CBT_OFF_RELOAD_SEL: begin
          rd_data <= {24'h00_0000, second_timer_reload_select, first_timer_reload_select};
        end
        `CBT_OFF_ROUTE_SEL: begin
          rd_data <= {8'h00, route_sel};
        end
        default: begin
          if ((bus_req.addr[1:0] == 2'b00) && (win < 3'd4)) begin
            for (int k = 0; k < 4; k++) begin
              if (three_byte && (k == 3)) begin
                rd_data[31:24] <= 8'h00;
              end else if (win[0]) begin
                rd_data[8*k +: 8] <= reload_reg[4*win[1] + k];
              end else begin
                rd_data[8*k +: 8] <= count_reg[4*win[1] + k];
              end
            end
          end
        end
      endcase
    end
  end

  // Overflow routing, registered so the lines are clean one-cycle pulses
  always_ff @(posedge clock) begin
    if (rst) begin
      first_route  <= '0;
      second_route <= '0;
    end else begin
      for (int n = 0; n < 2; n++) begin
        first_route.service[n]  <= ovf[route_sel[2*n +: 2]];
        first_route.out[n]      <= ovf[route_sel[4 + 2*n +: 2]];
        first_route.trig[n]     <= ovf[route_sel[8 + 2*n +: 2]];
        second_route.service[n] <= ovf[{1'b1, route_sel[12 + 2*n +: 2]}];
        second_route.out[n]     <= ovf[{1'b1, route_sel[16 + 2*n +: 2]}];
        second_route.trig[n]    <= ovf[{1'b1, route_sel[20 + 2*n +: 2]}];
      end
    end
  end

endmodule : cbt_timer_pair
`default_nettype wire

/* logic/cbt_params.svh */
`ifndef CBT_PARAMS_SVH
`define CBT_PARAMS_SVH

// Register byte addresses (bits [5:3] pick the window, bit 2 the three-byte view)
`define CBT_OFF_FIRST_COUNT   6'h00
`define CBT_OFF_FIRST_RELOAD  6'h08
`define CBT_OFF_SECOND_COUNT  6'h10
`define CBT_OFF_SECOND_RELOAD 6'h18
`define CBT_OFF_INPUT_CTRL    6'h20
`define CBT_OFF_RELOAD_SEL    6'h24
`define CBT_OFF_ROUTE_SEL     6'h28
`define CBT_THREE_BYTE_BIT    2

// Input control fields
`define CBT_SRC_LSB           0
`define CBT_WRAP_FIRST_BIT    16
`define CBT_WRAP_SECOND_BIT   17
`define CBT_CSRC_ZERO_LSB     18
`define CBT_CSRC_ONE_LSB      20

// Route select fields
`define CBT_ROUTE_FIRST_LSB   0
`define CBT_ROUTE_SECOND_LSB  12

// Reset values
`define CBT_INPUT_CTRL_RST    32'h0000_0000
`define CBT_RELOAD_SEL_RST    8'h00
`define CBT_ROUTE_SEL_RST     24'h00_0000
`define CBT_BYTE_RST          8'h00

`endif

/* logic/cbt_pkg.sv */
package cbt_pkg;

  // Count source of one 8-bit block
  typedef enum logic [1:0] {
    CBT_SRC_PREV  = 2'b00,
    CBT_SRC_CLOCK = 2'b01,
    CBT_SRC_SHARED_COUNT_INPUT_ZERO  = 2'b10,
    CBT_SRC_SHARED_COUNT_INPUT_ONE  = 2'b11
  } cbt_src_e;

  // Source of a shared count input
  typedef enum logic [1:0] {
    CBT_CSRC_EXT  = 2'b00,
    CBT_CSRC_LOW  = 2'b01,
    CBT_CSRC_HIGH = 2'b10,
    CBT_CSRC_NONE = 2'b11
  } cbt_csrc_e;

  // One register access
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [5:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } cbt_bus_req_s;

  // Overflow routing of one wide timer
  typedef struct packed {
    logic [1:0] service;
    logic [1:0] out;
    logic [1:0] trig;
  } cbt_route_s;

endpackage : cbt_pkg

/* sim/cbt_timer_pair_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module cbt_timer_pair_sva (
  // Clock and reset
  input wire logic                  clock,
  input wire logic                  rst,
  // Register port and routes
  input wire cbt_pkg::cbt_bus_req_s bus_req,
  input wire logic [31:0]           rd_data,
  input wire cbt_pkg::cbt_route_s   first_route,
  input wire cbt_pkg::cbt_route_s   second_route
);
  import cbt_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Short views of the request; a read result must trace back to its strobe
  wire logic        w  = bus_req.wr;
  wire logic        r  = bus_req.rd;
  wire logic [5:0]  ad = bus_req.addr;
  wire logic [31:0] d  = bus_req.wdata;
  wire logic        fb = bus_req.be == 4'hf;

  a_reset_clears: assert property (disable iff (1'b0)
    rst |=> rd_data == 32'h0 && first_route == 6'h0 && second_route == 6'h0)
    else $error("reset left state behind");
  a_unmapped_zero: assert property (
    r && ad >= 6'h2c |=> rd_data == 32'h0) else $error("unmapped read not zero");
  a_top_byte_zero: assert property (
    r && !ad[5] && ad[2] |=> rd_data[31:24] == 8'h0) else $error("top byte not zero");
  a_read_holds: assert property (
    !r |=> $stable(rd_data)) else $error("read data moved without a read");
  a_reload_word: assert property (
    w && !ad[5] && ad[3:0] == 4'h8 && fb ##1 r && ad == $past(ad)
    |=> rd_data == $past(d, 2)) else $error("reload word not read back");
  a_three_word: assert property (
    w && !ad[5] && ad[3:0] == 4'hc && fb ##1 r && ad == $past(ad)
    |=> rd_data == ($past(d, 2) & 32'h00ff_ffff)) else $error("three-byte view wrong");
  a_d_kept: assert property (
    r && !ad[5] && ad[3:0] == 4'h8 ##1 w && fb && ad == $past(ad) + 6'h4
    ##1 r && ad == $past(ad, 2) |=> rd_data[31:24] == $past(rd_data[31:24]))
    else $error("top block changed by three-byte store");
  a_byte_lane: assert property (
    w && ad == 6'h08 && bus_req.be == 4'h1 ##1 r && ad == 6'h08
    |=> rd_data[7:0] == $past(d[7:0], 2)) else $error("lane zero not read back");
  a_ctrl_back: assert property (
    w && ad == 6'h20 && fb ##1 r && ad == 6'h20
    |=> rd_data[21:0] == $past(d[21:0], 2)) else $error("input control not read back");

  // Main scenarios
  c_route: cover property (first_route.service[0]);
  c_three: cover property (w && ad == 6'h0c);
  c_second: cover property (r && ad == 6'h10);
endmodule : cbt_timer_pair_sva

bind cbt_timer_pair cbt_timer_pair_sva u_sva (.clock(clock), .rst(rst), .bus_req(bus_req),
  .rd_data(rd_data), .first_route(first_route), .second_route(second_route));
`default_nettype wire

/* sim/cbt_count_source_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cbt_count_source_model (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // Burst request
  input  wire logic       start,
  input  wire logic [1:0] sel,
  input  wire logic [7:0] count,
  // Event lines
  output logic [1:0]      ext_count,
  output logic            companion_low_overflow,
  output logic            companion_high_overflow,
  output logic            busy
);
  logic [7:0] left;
  logic       ph;
  // High one clock, low the next, so a level input sees separate events
  always_ff @(posedge clock) begin
    if (rst) begin
      left <= 8'h00;
      ph <= 1'b0;
    end else if (start) begin
      left <= count;
      ph <= 1'b0;
    end else if (left != 8'h00) begin
      ph <= !ph;
      if (ph) left <= left - 8'h01;
    end
  end
  // Only the chosen line pulses; the others rest low
  wire logic on = left != 8'h00 && !ph;
  assign busy = left != 8'h00;
  assign ext_count = {on && sel == 2'd3, on && sel == 2'd0};
  assign companion_low_overflow = on && sel == 2'd1;
  assign companion_high_overflow = on && sel == 2'd2;
endmodule : cbt_count_source_model
`default_nettype wire

/* sim/cascadable_byte_timer_pair_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module cascadable_byte_timer_pair_tb_top;
  import cbt_pkg::*;
  logic clock, rst, start, lo, hi, busy;
  logic [1:0] ext, sel;
  logic [7:0] n;
  logic [31:0] rd_data, seen, ex, ctrl;
  cbt_bus_req_s bus_req;
  cbt_route_s fr, sr;
  int mismatches, cmp_count, i, k, t;

  cbt_timer_pair dut (.clock(clock), .rst(rst), .bus_req(bus_req), .rd_data(rd_data),
    .ext_count(ext), .companion_low_overflow(lo), .companion_high_overflow(hi),
    .first_route(fr), .second_route(sr));
  cbt_count_source_model src (.clock(clock), .rst(rst), .start(start), .sel(sel),
    .count(n), .ext_count(ext), .companion_low_overflow(lo),
    .companion_high_overflow(hi), .busy(busy));

  // Module clock
  initial clock = 1'b0;
  always #5 clock = ~clock;

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] e);
    cmp_count++;
    if (got !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, got);
    end
  endtask : chk
  // Strobes stay up between calls so back-to-back requests need no gap
  task automatic wr(input logic [5:0] a, input logic [3:0] be, input logic [31:0] d);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, be: be, wdata: d};
    @(posedge clock);
  endtask : wr
  task automatic rd(input logic [5:0] a);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, be: 4'hf, wdata: 32'h0};
    @(posedge clock);
    #1 seen = rd_data;
  endtask : rd
  task automatic rdchk(input string nm, input logic [5:0] a, input logic [31:0] e);
    rd(a);
    chk(nm, seen, e);
  endtask : rdchk
  task automatic tally_and_finish;
    $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  // Bounded waits; running out counts as a mismatch
  task automatic wait_route;
    t = 0;
    do begin
      @(posedge clock);
      #1 t++;
    end while (fr.service[0] !== 1'b1 && t < 300);
    if (t >= 300) begin
      mismatches++;
      tally_and_finish();
    end
  endtask : wait_route
  task automatic burst(input logic [1:0] s, input logic [7:0] c);
    bus_req <= '0;
    sel <= s;
    n <= c;
    start <= 1'b1;
    @(posedge clock);
    start <= 1'b0;
    for (t = 0; t < 40; t++) begin
      @(posedge clock);
      #1 if (!busy) break;
    end
    if (busy) begin
      mismatches++;
      tally_and_finish();
    end
  endtask : burst

  initial begin
    rst = 1'b1;
    start = 1'b0;
    sel = 2'd0;
    n = 8'h00;
    bus_req = '0;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    // Every window, control and unmapped place reads zero after reset
    for (i = 0; i < 16; i++) rdchk("reset map", 6'(i * 4), 32'h0);
    // Full window: word, each lane, then the upper half
    wr(6'h00, 4'hf, 32'h4433_2211);
    rdchk("count word", 6'h00, 32'h4433_2211);
    ex = 32'h8877_6655;
    wr(6'h08, 4'hf, ex);
    rdchk("reload word", 6'h08, ex);
    for (k = 0; k < 4; k++) begin
      ex[8*k +: 8] = 8'(8'h10 + k);
      wr(6'h08, 4'(1 << k), {4{8'(8'h10 + k)}});
      rdchk("reload lane", 6'h08, ex);
    end
    ex[31:16] = 16'haaaa;
    wr(6'h08, 4'hc, 32'haaaa_0000);
    rdchk("reload half", 6'h08, ex);
    // Three-byte view: top block untouched, lane three refused
    rd(6'h08);
    wr(6'h0c, 4'hf, 32'hffcb_cdef);
    rdchk("top kept", 6'h08, {ex[31:24], 24'hcbcdef});
    wr(6'h0c, 4'hf, 32'h0012_3456);
    rdchk("three view", 6'h0c, 32'h0012_3456);
    wr(6'h0c, 4'h8, 32'h5500_0000);
    rdchk("three top", 6'h0c, 32'h0012_3456);
    rdchk("full after", 6'h08, {ex[31:24], 24'h123456});
    // Clocked A block: first overflow, routing pick and reload period
    wr(6'h28, 4'hf, 32'h0000_0010);
    wr(6'h08, 4'h1, 32'h0000_00fc);
    wr(6'h00, 4'h1, 32'h0000_00fd);
    wr(6'h20, 4'hf, 32'h0000_0001);
    bus_req <= '0;
    wait_route();
    chk("first wrap", 32'(t), 32'd3);
    chk("route pick", {26'h0, fr}, 32'h0000_003b);
    chk("second quiet", {26'h0, sr}, 32'h0);
    wait_route();
    chk("reload period", 32'(t), 32'd4);
    // Shared inputs from each source; an unselected line pulses first
    for (k = 0; k < 4; k++) begin
      ctrl = 32'(((2 + k / 2) << 8) | ((k < 2 ? k : 3) << 18) | ((k == 2 ? 2 : k * 3 % 9) << 20));
      wr(6'h20, 4'hf, ctrl);
      rdchk("input ctrl", 6'h20, ctrl);
      wr(6'h10, 4'hf, 32'h0);
      burst(2'(k + 1), 8'd3);
      burst(2'(k), 8'(5 + k));
      rdchk("shared count", 6'h10, 32'(5 + k));
    end
    // Cross chain with the first timer low: its D carry reaches second A undelayed
    wr(6'h00, 4'hf, 32'hfe00_0000);
    wr(6'h10, 4'hf, 32'h0);
    wr(6'h20, 4'hf, 32'h0002_0040);
    bus_req <= '0;
    repeat (2) @(posedge clock);
    rdchk("cross carry", 6'h10, 32'h1);
    rdchk("own wrap late", 6'h00, 32'hab00_0001);
    tally_and_finish();
  end
endmodule : cascadable_byte_timer_pair_tb_top
`default_nettype wire
